// *** rtl/vic_pkg.sv ***
// vic_pkg: register map, field positions and reset values of the vectored interrupt config block
// assumes one 100 MHz clock domain and a plain strobe register port
package vic_pkg;
  localparam int unsigned VIC_AW = 8;
  // register offsets (byte addresses)
  localparam logic [7:0] VIC_OFF_CONTROL = 8'h00;
  localparam logic [7:0] VIC_OFF_FLAG0 = 8'h10;
  localparam logic [7:0] VIC_OFF_ENABLE0 = 8'h20;
  localparam logic [7:0] VIC_OFF_PRIO0 = 8'h40;
  // event words sit above the 24 priority words (0x40..0x9f)
  localparam logic [7:0] VIC_OFF_EVT_STATUS = 8'ha0;
  localparam logic [7:0] VIC_OFF_EVT_CLEAR = 8'ha4;
  localparam logic [7:0] VIC_OFF_EVT_ENABLE = 8'ha8;
  localparam logic [7:0] VIC_OFF_VSTATUS = 8'hac;
  // control field positions
  localparam int unsigned VIC_SPACING_LSB = 16;
  localparam int unsigned VIC_SPACING_W = 7;
  localparam int unsigned VIC_MODE_BIT = 12;
  localparam int unsigned VIC_PROX_LSB = 8;
  localparam int unsigned VIC_PROX_W = 3;
  localparam int unsigned VIC_EP_W = 5;
  localparam logic [31:0] VIC_CONTROL_MASK = 32'h007f_171f;
  localparam logic [31:0] VIC_CONTROL_RST = 32'h0000_0000;
  // priority lane layout
  localparam int unsigned VIC_PRI_LSB = 2;
  localparam int unsigned VIC_SUB_LSB = 0;
  localparam logic [31:0] VIC_PRIO_MASK = 32'h1f1f_1f1f;
  // vector map
  localparam int unsigned VIC_NUM_VEC = 96;
  localparam int unsigned VIC_CAPCMP_FIRST = 74;
  localparam int unsigned VIC_CAPCMP_LAST = 87;
  localparam int unsigned VIC_SPACING_UNIT = 8;
  // persistent sources: vectors 56..61 and 65..73
  localparam logic [95:0] VIC_PERSIST = 96'h0000_03fe_3f00_0000_0000_0000;
  // event bits
  localparam int unsigned VIC_EVT_W = 2;
  localparam int unsigned VIC_EVT_EXT = 0;
  localparam int unsigned VIC_EVT_REQ = 1;
endpackage

// *** rtl/vic_top.sv ***
// vic_top: flag/enable/priority registers, control register, edge detect and request output
// assumes a strobe register port on mclk and asynchronous peripheral and external pins
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - capture/compare unit k uses even vector 72+2k for events, odd next for timer
// - serial sources hold requests while asserted; capture/compare and reserved do not
// - spacing field one-hot: zero gives 0 bytes, bit k gives 8 shl k bytes
// - spacing is ignored while multi-vector mode is off
// - control holds spacing 22:16, mode 12, threshold 10:8, polarity 4:0, reset zero
// - control bits 31:23, 15:13, 11, 7:5 read zero and ignore writes
// - mode one gives multi-vectored operation, zero a single shared vector
// - threshold zero disables proximity timer, p lets priority p or lower start it
// - polarity bit one picks rising edge, zero falling edge, per external input
module vic_top
  import vic_pkg::*;
#(
  parameter int unsigned NUM_VEC = vic_pkg::VIC_NUM_VEC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [vic_pkg::VIC_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // sources
  input wire logic [NUM_VEC-1:0] src_req,
  input wire logic [vic_pkg::VIC_EP_W-1:0] ext_irq_pin,
  // core side
  output logic core_req,
  output logic [6:0] core_vector,
  output logic [2:0] core_priority,
  output logic [1:0] core_subpriority,
  output logic [9:0] core_vec_offset,
  output logic multi_vector_mode,
  output logic prox_timer_start,
  output logic irq
);
  import vic_pkg::*;

  localparam int unsigned NREG = (NUM_VEC + 31) / 32;
  localparam int unsigned NPRI = NUM_VEC / 4;
  localparam int unsigned EXT_BASE = 3;

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q;
  logic [NUM_VEC-1:0] flag_q;
  logic [NUM_VEC-1:0] enable_q;
  logic [7:0] lane_q [NUM_VEC];
  logic [VIC_EVT_W-1:0] evt_stat_q;
  logic [VIC_EVT_W-1:0] evt_en_q;
  logic [VIC_EP_W-1:0] ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
  logic [NUM_VEC-1:0] src_s1_q, src_s2_q, src_s3_q;
  logic core_req_q;

  logic [VIC_SPACING_W-1:0] vector_spacing;
  logic [VIC_PROX_W-1:0] proximity_threshold;
  logic [VIC_EP_W-1:0] ext_edge_sel;
  assign vector_spacing = ctrl_q[VIC_SPACING_LSB +: VIC_SPACING_W];
  assign multi_vector_mode = ctrl_q[VIC_MODE_BIT];
  assign proximity_threshold = ctrl_q[VIC_PROX_LSB +: VIC_PROX_W];
  assign ext_edge_sel = ctrl_q[VIC_EP_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_q <= VIC_CONTROL_RST;
    end else if (reg_wr && reg_addr == VIC_OFF_CONTROL) begin
      ctrl_q <= reg_wdata & VIC_CONTROL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: a change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
      ext_lvl_q <= '0;
      src_s1_q <= '0;
      src_s2_q <= '0;
      src_s3_q <= '0;
    end else begin
      ext_s1_q <= ext_irq_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      for (int i = 0; i < VIC_EP_W; i++) begin
        if (ext_s2_q[i] == ext_s3_q[i]) begin
          ext_lvl_q[i] <= ext_s3_q[i];
        end
      end
      src_s1_q <= src_req;
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
    end
  end

  logic [VIC_EP_W-1:0] ext_edge;
  logic [VIC_EP_W-1:0] ext_new;
  always_comb begin
    for (int i = 0; i < VIC_EP_W; i++) begin
      ext_new[i] = (ext_s2_q[i] == ext_s3_q[i]) ? ext_s3_q[i] : ext_lvl_q[i];
      // rising when polarity set, falling when clear
      ext_edge[i] = ext_edge_sel[i] ? (ext_new[i] & ~ext_lvl_q[i])
                                    : (~ext_new[i] & ext_lvl_q[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flag and enable bits, one generate entry per vector
  // stable level one cycle back, for one-shot sources
  logic [NUM_VEC-1:0] src_s3_q_d;

  genvar gv;
  generate
    for (gv = 0; gv < NUM_VEC; gv++) begin : g_vec
      localparam int unsigned RIDX = gv / 32;
      localparam int unsigned BIT = gv % 32;
      localparam logic [7:0] FADDR = 8'(VIC_OFF_FLAG0 + 4 * RIDX);
      localparam logic [7:0] EADDR = 8'(VIC_OFF_ENABLE0 + 4 * RIDX);
      localparam logic [7:0] PADDR = 8'(VIC_OFF_PRIO0 + 4 * (gv / 4));
      logic stable;
      logic hit;
      assign stable = src_s2_q[gv] & src_s3_q[gv];
      if (gv >= EXT_BASE && gv < EXT_BASE + VIC_EP_W) begin : g_ext
        assign hit = ext_edge[gv - EXT_BASE];
      end else if (VIC_PERSIST[gv]) begin : g_per
        assign hit = stable;
      end else begin : g_pulse
        assign hit = stable & ~src_s3_q_d[gv];
      end
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          flag_q[gv] <= 1'b0;
        end else if (hit) begin
          flag_q[gv] <= 1'b1; // set wins over a clearing write
        end else if (reg_wr && reg_addr == FADDR) begin
          flag_q[gv] <= reg_wdata[BIT];
        end
      end
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          enable_q[gv] <= 1'b0;
        end else if (reg_wr && reg_addr == EADDR) begin
          enable_q[gv] <= reg_wdata[BIT];
        end
      end
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          lane_q[gv] <= 8'h00;
        end else if (reg_wr && reg_addr == PADDR) begin
          lane_q[gv] <= reg_wdata[8*(gv%4) +: 8] & VIC_PRIO_MASK[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      src_s3_q_d <= '0;
    end else begin
      src_s3_q_d <= src_s2_q & src_s3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request selection: lowest vector with highest priority among pending ones
  logic [NUM_VEC-1:0] pending;
  assign pending = flag_q & enable_q;
  logic found;
  logic [6:0] win_vec;
  logic [4:0] win_key;
  always_comb begin
    found = 1'b0;
    win_vec = '0;
    win_key = '0;
    for (int i = 0; i < NUM_VEC; i++) begin
      if (pending[i] && (!found || lane_q[i][4:0] > win_key)) begin
        found = 1'b1;
        win_vec = 7'(i);
        win_key = lane_q[i][4:0];
      end
    end
  end

  // byte offset of the vector from the base
  logic [9:0] spacing_bytes;
  always_comb begin
    spacing_bytes = '0;
    for (int k = 0; k < VIC_SPACING_W; k++) begin
      if (vector_spacing[k]) begin
        spacing_bytes = 10'(VIC_SPACING_UNIT << k);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      core_req_q <= 1'b0;
      core_vector <= '0;
      core_priority <= '0;
      core_subpriority <= '0;
      core_vec_offset <= '0;
      prox_timer_start <= 1'b0;
    end else begin
      core_req_q <= found;
      core_priority <= win_key[4:2];
      core_subpriority <= win_key[1:0];
      if (multi_vector_mode) begin
        core_vector <= win_vec;
        core_vec_offset <= 10'(win_vec * spacing_bytes);
      end else begin
        core_vector <= '0;
        core_vec_offset <= '0;
      end
      prox_timer_start <= found && (proximity_threshold != '0)
                          && (win_key[4:2] <= proximity_threshold);
    end
  end
  assign core_req = core_req_q;

  ////////////////////////////////////////////////////////////////////////
  // event status, clear and enable
  logic [VIC_EVT_W-1:0] evt_set;
  assign evt_set[VIC_EVT_EXT] = |ext_edge;
  assign evt_set[VIC_EVT_REQ] = found & ~core_req_q;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      evt_stat_q <= '0;
    end else begin
      for (int i = 0; i < VIC_EVT_W; i++) begin
        if (evt_set[i]) begin
          evt_stat_q[i] <= 1'b1;
        end else if (reg_wr && reg_addr == VIC_OFF_EVT_CLEAR && reg_wdata[i]) begin
          evt_stat_q[i] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      evt_en_q <= '0;
    end else if (reg_wr && reg_addr == VIC_OFF_EVT_ENABLE) begin
      evt_en_q <= reg_wdata[VIC_EVT_W-1:0];
    end
  end
  assign irq = |(evt_stat_q & evt_en_q);

  ////////////////////////////////////////////////////////////////////////
  // read port, data in the cycle after the strobe
  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    if (reg_addr == VIC_OFF_CONTROL) begin
      rd_d = ctrl_q;
    end else if (reg_addr == VIC_OFF_EVT_STATUS) begin
      rd_d[VIC_EVT_W-1:0] = evt_stat_q;
    end else if (reg_addr == VIC_OFF_EVT_ENABLE) begin
      rd_d[VIC_EVT_W-1:0] = evt_en_q;
    end else if (reg_addr == VIC_OFF_VSTATUS) begin
      rd_d = {15'h0000, core_req_q, core_vector, core_priority, core_subpriority, 4'h0};
    end
    for (int i = 0; i < NUM_VEC; i++) begin
      if (reg_addr == 8'(VIC_OFF_FLAG0 + 4 * (i / 32))) begin
        rd_d[i % 32] = flag_q[i];
      end
      if (reg_addr == 8'(VIC_OFF_ENABLE0 + 4 * (i / 32))) begin
        rd_d[i % 32] = enable_q[i];
      end
      if (reg_addr == 8'(VIC_OFF_PRIO0 + 4 * (i / 4))) begin
        rd_d[8*(i%4) +: 8] = lane_q[i];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule // vic_top
`default_nettype wire

// *** sim/vic_core_model.sv ***
// vic_core_model: core side, latches the vector of each new request
// assumes the core outputs of vic_top on mclk
`timescale 1ns/10ps
`default_nettype none
module vic_core_model (
  // core side
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic core_req,
  input wire logic [6:0] core_vector,
  output logic [6:0] taken_vector
);
  logic req_q;
  always_ff @(posedge mclk) begin
    req_q <= reset_n & core_req;
    if (!reset_n) taken_vector <= 7'h00;
    else if (core_req && !req_q) taken_vector <= core_vector;
  end
endmodule // vic_core_model
`default_nettype wire

// *** sim/vic_top_assertions.sv ***
// vic_top_assertions: port checks for vic_top
// assumes one mclk domain; bound to vic_top below
`timescale 1ns/10ps
`default_nettype none
module vic_top_assertions
  import vic_pkg::*;
#(
  parameter int unsigned NUM_VEC = vic_pkg::VIC_NUM_VEC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [vic_pkg::VIC_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // core side
  input wire logic core_req,
  input wire logic [6:0] core_vector,
  input wire logic [2:0] core_priority,
  input wire logic [9:0] core_vec_offset,
  input wire logic multi_vector_mode,
  input wire logic prox_timer_start,
  input wire logic irq
);
  // shadow of the control register as software wrote it
  logic [31:0] ctrl_q;
  always_ff @(posedge mclk) begin
    if (!reset_n) ctrl_q <= 32'h0000_0000;
    else if (reg_wr && reg_addr == VIC_OFF_CONTROL) ctrl_q <= reg_wdata & 32'h007f_171f;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_ctrl_read: assert property (
    reg_rd && reg_addr == VIC_OFF_CONTROL |=> reg_rdata == $past(ctrl_q))
    else $error("control read differs from written value");
  a_mode_bit: assert property (multi_vector_mode == ctrl_q[12])
    else $error("mode output differs from control bit");
  a_single_vector: assert property (
    !multi_vector_mode && $past(!multi_vector_mode) |->
    core_vector == 7'h00 && core_vec_offset == 10'h000)
    else $error("single mode shows a vector or offset");
  a_spacing_zero: assert property (
    multi_vector_mode && ctrl_q[22:16] == 7'h00 && $stable(ctrl_q) |-> core_vec_offset == 10'h000)
    else $error("zero spacing gives nonzero offset");
  a_prox_off: assert property ((ctrl_q[10:8] == 3'h0) [*3] |-> !prox_timer_start)
    else $error("proximity start while threshold zero");
  a_prox_level: assert property (
    ($stable(ctrl_q)) [*3] ##0 prox_timer_start |-> core_priority <= ctrl_q[10:8])
    else $error("proximity start above threshold");
  a_vector_range: assert property (
    core_req && multi_vector_mode |-> core_vector < 7'(NUM_VEC))
    else $error("vector out of range");
  cover property (core_req && multi_vector_mode);
  cover property (prox_timer_start);
  cover property (irq);
endmodule // vic_top_assertions
bind vic_top vic_top_assertions #(.NUM_VEC(NUM_VEC)) u_vic_top_assertions (
  .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_req(core_req),
  .core_vector(core_vector), .core_priority(core_priority),
  .core_vec_offset(core_vec_offset), .multi_vector_mode(multi_vector_mode),
  .prox_timer_start(prox_timer_start), .irq(irq));
`default_nettype wire

// *** sim/vic_top_bench.sv ***
// vic_top_bench: register-level tests of vic_top
// assumes vic_pkg, the checker and vic_core_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module vic_top_bench;
  import vic_pkg::*;
  logic mclk, reset_n, reg_wr, reg_rd, core_req, multi_mode, prox, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [95:0] src_req;
  logic [4:0] ext_irq_pin;
  logic [6:0] core_vector, taken;
  logic [2:0] core_priority;
  logic [1:0] core_sub;
  logic [9:0] core_off;
  int bad_count, cmp_count, cyc;
  vic_top u_vic_top (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_req(src_req), .ext_irq_pin(ext_irq_pin), .core_req(core_req),
    .core_vector(core_vector), .core_priority(core_priority),
    .core_subpriority(core_sub), .core_vec_offset(core_off),
    .multi_vector_mode(multi_mode), .prox_timer_start(prox), .irq(irq));
  vic_core_model u_vic_core_model (.mclk(mclk), .reset_n(reset_n),
    .core_req(core_req), .core_vector(core_vector), .taken_vector(taken));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, src_req} = '0;
    ext_irq_pin = 5'h0a;
    idle(3);
    reset_n <= 1'b1;
    rdchk(VIC_OFF_CONTROL, 32'h0000_0000);
    wr32(VIC_OFF_CONTROL, 32'hff40_ffff);
    rdchk(VIC_OFF_CONTROL, 32'h0040_171f);
    rdchk(8'hfc, 32'h0000_0000);
    // even pins rise, odd pins fall: all five edges count
    wr32(VIC_OFF_CONTROL, 32'h0000_0015);
    ext_irq_pin <= 5'h15;
    idle(8);
    rdchk(VIC_OFF_FLAG0, 32'h0000_00f8);
    rdchk(VIC_OFF_EVT_STATUS, 32'h0000_0001);
    chk(irq, 0);
    wr32(VIC_OFF_EVT_ENABLE, 32'h1);
    idle(2);
    chk(irq, 1);
    wr32(VIC_OFF_EVT_CLEAR, 32'h1);
    idle(2);
    chk(irq, 0);
    wr32(VIC_OFF_FLAG0, 32'h0);
    ext_irq_pin <= 5'h0a;
    idle(8);
    rdchk(VIC_OFF_FLAG0, 32'h0000_0000);
    // vector 1 pending by a flag write, each one-hot spacing code and zero
    wr32(VIC_OFF_FLAG0, 32'h2);
    idle(4);
    chk(core_req, 0);
    wr32(VIC_OFF_ENABLE0, 32'h2);
    for (int k = 0; k < 8; k++) begin
      wr32(VIC_OFF_CONTROL, 32'h1000 | ((k < 7 ? 32'h1 << k : 32'h0) << 16));
      idle(4);
      chk(core_req, 1);
      chk({multi_mode, core_vector}, {1'b1, 7'd1});
      chk(core_off, k < 7 ? 32'd8 << k : 32'd0);
    end
    wr32(VIC_OFF_CONTROL, 32'h0040_0000);
    idle(4);
    chk({multi_mode, core_vector, core_off}, 0);
    wr32(VIC_OFF_ENABLE0, 32'h0);
    // seventh unit capture vector, priority 3 sub 1, threshold 3
    wr32(VIC_OFF_CONTROL, 32'h0001_1300);
    wr32(8'h94, 32'h000d_0000);
    wr32(8'h28, 32'h0040_0000);
    src_req[86] <= 1'b1;
    idle(2);
    src_req[86] <= 1'b0;
    idle(8);
    rdchk(8'h18, 32'h0040_0000);
    rdchk(VIC_OFF_VSTATUS, 32'h0001_acd0);
    rdchk(VIC_OFF_EVT_STATUS, 32'h0000_0002);
    chk(taken, 86);
    chk(core_off, 688);
    chk({core_priority, core_sub}, 5'h0d);
    chk(prox, 1);
    wr32(VIC_OFF_CONTROL, 32'h0001_1200);
    idle(4);
    chk(prox, 0);
    wr32(8'h18, 32'h0);
    idle(4);
    chk(core_req, 0);
    // held sources: only the serial one re-sets its flag
    src_req[56] <= 1'b1;
    src_req[86] <= 1'b1;
    idle(8);
    wr32(8'h14, 32'h0);
    wr32(8'h18, 32'h0);
    idle(8);
    rdchk(8'h14, 32'h0100_0000);
    rdchk(8'h18, 32'h0000_0000);
    complete_run();
  end
endmodule // vic_top_bench
`default_nettype wire
